// ===== verilog/adc_seq_pkg.sv
// package for the converter selection and sleep sequencer
// assumes a single 100 MHz system clock domain
package adc_seq_pkg;
   localparam int CLK_MHZ = 100;
   localparam int SEL_CHAN_W = 5;
   localparam int SEL_REF_W = 2;
   localparam int NORMAL_CYCLES = 13;
   localparam int FIRST_CYCLES = 25;
   localparam int FIRST_SAMPLE_CYCLE = 13;
   localparam int NORMAL_SAMPLE_CYCLE = 1;
   localparam int SETTLE_US = 125;
   localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
   localparam logic [1:0] REF_EXT_PIN = 2'h0;
   localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
   localparam logic [1:0] REF_RESERVED = 2'h2;
   localparam logic [1:0] REF_INTERNAL = 2'h3;
   localparam logic [9:0] FULL_SCALE = 10'h3ff;
   localparam logic [4:0] SEL_CHAN_RESET = 5'h00;
   localparam logic [1:0] SEL_REF_RESET = 2'h0;
   localparam logic [4:0] CNT_W_ONE = 5'h01;

   // channel/gain plus reference, as software writes it
   typedef struct packed {
      logic [1:0] reference_select;
      logic [4:0] channel_gain_select;
   } selection_t;

   // analog reference switch controls
   typedef struct packed {
      logic ext_pin;
      logic analog_supply;
      logic internal_ref;
   } ref_switch_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_CONV = 3'b100
   } conv_state_t;
endpackage : adc_seq_pkg

// ===== verilog/adc_sel_buffer.sv
// selection buffer: temporary and applied copies of the selection
// assumes one clock; update enable comes from the sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_sel_buffer
   import adc_seq_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // software side
   input wire logic wr_i,
   input wire selection_t wdata_i,
   output selection_t buffered_o,
   // converter side
   input wire logic update_en_i,
   output selection_t applied_o
);
   typedef struct packed {
      selection_t buffered;
      selection_t applied;
   } buf_state_t;

   buf_state_t s;
   buf_state_t next_s;

   // buffer takes every write; applied follows only while unlocked
   always_comb begin
      next_s = s;
      if (wr_i) begin
         next_s.buffered = wdata_i;
      end
      if (update_en_i) begin
         next_s.applied = next_s.buffered;
      end
   end

   // state register
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s <= '{buffered: '{SEL_REF_RESET, SEL_CHAN_RESET},
                applied: '{SEL_REF_RESET, SEL_CHAN_RESET}};
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign buffered_o = s.buffered;
   assign applied_o = s.applied;

   // locked selection must not move
   property p_lock_holds;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (ce_i && !update_en_i) |=> $stable(s.applied);
   endproperty
   a_lock_holds: assert property (p_lock_holds) else $error("applied moved while locked");
endmodule : adc_sel_buffer
`default_nettype wire

// ===== verilog/adc_select_and_sleep_sequencer.sv
// converter control: selection locking, conversion sequencing, sleep start
// assumes adc_tick_i is a one-cycle pulse per rising converter clock edge
// Operation
// - software selection is held in a temporary buffer, always accessible.
// - applied selection follows buffer until conversion starts, then freezes.
// - updating resumes in the last converter cycle before completion.
// - conversion starts on first converter edge after the start write.
// - boundary-scan enable removes the four upper port F channels.
// - free-run auto conversion still uses previous channel after a change.
// - three references: analog supply, internal 2.56 V, external pin.
// - single-ended input above reference returns full-scale code.
// - canceler sleep with preconditions met starts a conversion once halted.
// - completion raises interrupt request even after an earlier wake.
// - other sleep modes do not disable the converter.
// - reference codes: 00 pin, 01 supply, 10 reserved, 11 internal.
// - normal conversion 13 cycles, then done flag; single clears start.
// - first conversion after enable lasts 25 cycles, samples at 13.5.
// - free running restarts right after completion, start bit kept.
`timescale 1ns/1ps
`default_nettype none
module adc_select_and_sleep_sequencer
   import adc_seq_pkg::*;
#(
   parameter int NORMAL_LEN = NORMAL_CYCLES,
   parameter int FIRST_LEN = FIRST_CYCLES
)(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // converter clock tick
   input wire logic adc_tick_i,
   // selection register access
   input wire logic sel_wr_i,
   input wire selection_t sel_wdata_i,
   output selection_t sel_rdata_o,
   // control bits
   input wire logic converter_enable_i,
   input wire logic free_run_select_i,
   input wire logic start_set_i,
   input wire logic done_clear_i,
   input wire logic int_enable_i,
   // sleep control
   input wire logic sleep_canceler_mode_i,
   input wire logic cpu_halted_i,
   // boundary-scan enable
   input wire logic scan_enable_i,
   // analog side
   input wire logic compare_over_ref_i,
   input wire logic [9:0] raw_result_i,
   output selection_t applied_sel_o,
   output ref_switch_t ref_switch_o,
   output logic [3:0] upper_chan_avail_o,
   output logic sample_o,
   output logic analog_power_o,
   // status
   output logic conversion_start_bit_o,
   output logic conversion_done_flag_o,
   output logic busy_o,
   output logic irq_o,
   output logic [9:0] result_o
);
   typedef struct packed {
      conv_state_t st;
      logic [4:0] cnt;
      logic [4:0] len;
      logic first_pending;
      logic start_bit;
      logic done_flag;
      logic sample;
      logic [9:0] result;
      logic prev_en;
      logic prev_halted;
   } seq_state_t;

   seq_state_t s;
   seq_state_t next_s;
   logic update_en;
   logic last_cycle;
   logic halt_start;
   selection_t applied;

   // decode a reference code into switch controls
   function automatic ref_switch_t ref_decode(input logic [1:0] code);
      ref_switch_t r;
      r = '0;
      unique case (code)
         REF_EXT_PIN: r.ext_pin = 1'b1;
         REF_ANALOG_SUPPLY: r.analog_supply = 1'b1;
         REF_INTERNAL: r.internal_ref = 1'b1;
         default: r = '0; // reserved code connects nothing
      endcase
      return r;
   endfunction : ref_decode

   adc_sel_buffer u_sel (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .wr_i(sel_wr_i),
      .wdata_i(sel_wdata_i),
      .buffered_o(sel_rdata_o),
      .update_en_i(update_en),
      .applied_o(applied)
   );

   // last converter cycle: counter at final count
   assign last_cycle = (s.st == ST_CONV) && (s.cnt == s.len);
   // unlock outside a conversion and in its final cycle
   assign update_en = (s.st != ST_CONV) || last_cycle;
   // canceler sleep auto-start on halting edge
   assign halt_start = sleep_canceler_mode_i && cpu_halted_i && !s.prev_halted
      && converter_enable_i && !free_run_select_i && int_enable_i
      && (s.st == ST_IDLE);

   // sequencer next state
   always_comb begin
      next_s = s;
      next_s.sample = 1'b0;
      next_s.prev_en = converter_enable_i;
      next_s.prev_halted = cpu_halted_i;
      // rising enable arms an extended first conversion
      if (converter_enable_i && !s.prev_en) begin
         next_s.first_pending = 1'b1;
      end
      if (start_set_i || halt_start) begin
         next_s.start_bit = 1'b1;
      end
      if (done_clear_i) begin
         next_s.done_flag = 1'b0;
      end
      unique case (s.st)
         ST_IDLE: begin
            if (converter_enable_i && next_s.start_bit) begin
               next_s.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (adc_tick_i) begin
               next_s.st = ST_CONV;
               next_s.cnt = CNT_W_ONE;
               next_s.len = s.first_pending ? 5'(FIRST_LEN) : 5'(NORMAL_LEN);
               next_s.first_pending = 1'b0;
            end
         end
         ST_CONV: begin
            if (adc_tick_i) begin
               if (s.cnt == (s.len == 5'(FIRST_LEN) ? 5'(FIRST_SAMPLE_CYCLE)
                                                     : 5'(NORMAL_SAMPLE_CYCLE))) begin
                  next_s.sample = 1'b1;
               end
               if (last_cycle) begin
                  next_s.done_flag = 1'b1;
                  // over-range single-ended input pins at full scale
                  next_s.result = compare_over_ref_i ? FULL_SCALE : raw_result_i;
                  if (free_run_select_i) begin
                     next_s.cnt = CNT_W_ONE;
                     next_s.len = 5'(NORMAL_LEN);
                  end else begin
                     next_s.start_bit = start_set_i;
                     next_s.st = ST_IDLE;
                  end
               end else begin
                  next_s.cnt = s.cnt + CNT_W_ONE;
               end
            end
         end
         default: next_s.st = ST_IDLE;
      endcase
      // disabling aborts the conversion and clears the start bit; re-enabling rearms the first conversion
      if (!converter_enable_i) begin
         next_s.st = ST_IDLE;
         next_s.start_bit = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s <= '{st: ST_IDLE, cnt: 5'h00, len: 5'h00, first_pending: 1'b1,
                start_bit: 1'b0, done_flag: 1'b0, sample: 1'b0, result: 10'h000,
                prev_en: 1'b0, prev_halted: 1'b0};
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   // outputs
   assign applied_sel_o = applied;
   assign ref_switch_o = ref_decode(applied.reference_select);
   assign upper_chan_avail_o = scan_enable_i ? 4'h0 : 4'hf;
   assign sample_o = s.sample;
   assign analog_power_o = converter_enable_i;
   assign conversion_start_bit_o = s.start_bit;
   assign conversion_done_flag_o = s.done_flag;
   assign busy_o = (s.st != ST_IDLE);
   assign irq_o = s.done_flag && int_enable_i;
   assign result_o = s.result;

   // conversion sequencing, unlock, scan, sleep start and full-scale checks
   sequence s_normal_run;
      (s.st == ST_CONV && s.cnt == CNT_W_ONE && s.len == 5'(NORMAL_LEN));
   endsequence
   property p_done_after_run;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (last_cycle && adc_tick_i && ce_i && converter_enable_i) |=> s.done_flag;
   endproperty
   a_done_after_run: assert property (p_done_after_run) else $error("done not set");
   property p_first_len;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (s.st == ST_WAIT && adc_tick_i && ce_i && s.first_pending && converter_enable_i)
         |=> (s.len == 5'(FIRST_LEN));
   endproperty
   a_first_len: assert property (p_first_len) else $error("first length wrong");
   property p_start_on_tick;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (s.st == ST_WAIT && !adc_tick_i && ce_i) |=> (s.st != ST_CONV);
   endproperty
   a_start_on_tick: assert property (p_start_on_tick) else $error("early start");
   property p_single_clears;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (last_cycle && adc_tick_i && ce_i && !free_run_select_i && !start_set_i
          && converter_enable_i) |=> !s.start_bit;
   endproperty
   a_single_clears: assert property (p_single_clears) else $error("start not cleared");
   property p_free_run;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (last_cycle && adc_tick_i && ce_i && free_run_select_i && converter_enable_i)
         |=> (s_normal_run and s.start_bit);
   endproperty
   a_free_run: assert property (p_free_run) else $error("free run not restarted");
   property p_unlock_last;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         last_cycle |-> update_en;
   endproperty
   a_unlock_last: assert property (p_unlock_last) else $error("not unlocked at end");
   property p_scan_block;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         scan_enable_i |-> (upper_chan_avail_o == 4'h0);
   endproperty
   a_scan_block: assert property (p_scan_block) else $error("upper channels live");
   property p_halt_start;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (halt_start && ce_i) |=> (s.start_bit && s.st == ST_WAIT);
   endproperty
   a_halt_start: assert property (p_halt_start) else $error("no sleep start");
   property p_full_scale;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
         (last_cycle && adc_tick_i && ce_i && compare_over_ref_i && converter_enable_i)
         |=> (s.result == FULL_SCALE);
   endproperty
   a_full_scale: assert property (p_full_scale) else $error("no full scale");
endmodule : adc_select_and_sleep_sequencer
`default_nettype wire

// ===== dv/test_adc_select_and_sleep_sequencer.sv
// self-checking bench for the converter selection and sleep sequencer
// assumes the package constants and a 100 MHz clock; ticks every 4 clocks
`timescale 1ns/1ps
`default_nettype none
module test_adc_select_and_sleep_sequencer;
   import adc_seq_pkg::*;

   logic clk_sys_i, rst_n_i, ce_i, adc_tick_i, sel_wr_i;
   selection_t sel_wdata_i, sel_rdata_o, applied_sel_o;
   logic converter_enable_i, free_run_select_i, start_set_i, done_clear_i, int_enable_i;
   logic sleep_canceler_mode_i, cpu_halted_i, scan_enable_i, compare_over_ref_i;
   logic [9:0] raw_result_i, result_o;
   ref_switch_t ref_switch_o;
   logic [3:0] upper_chan_avail_o;
   logic sample_o, analog_power_o, conversion_start_bit_o, conversion_done_flag_o;
   logic busy_o, irq_o;
   logic [1:0] div;
   int tick_count, mismatches, check_count;

   adc_select_and_sleep_sequencer adc_select_and_sleep_sequencer_inst (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .adc_tick_i(adc_tick_i),
      .sel_wr_i(sel_wr_i), .sel_wdata_i(sel_wdata_i), .sel_rdata_o(sel_rdata_o),
      .converter_enable_i(converter_enable_i), .free_run_select_i(free_run_select_i),
      .start_set_i(start_set_i), .done_clear_i(done_clear_i), .int_enable_i(int_enable_i),
      .sleep_canceler_mode_i(sleep_canceler_mode_i), .cpu_halted_i(cpu_halted_i),
      .scan_enable_i(scan_enable_i), .compare_over_ref_i(compare_over_ref_i),
      .raw_result_i(raw_result_i), .applied_sel_o(applied_sel_o), .ref_switch_o(ref_switch_o),
      .upper_chan_avail_o(upper_chan_avail_o), .sample_o(sample_o),
      .analog_power_o(analog_power_o), .conversion_start_bit_o(conversion_start_bit_o),
      .conversion_done_flag_o(conversion_done_flag_o), .busy_o(busy_o), .irq_o(irq_o),
      .result_o(result_o));

   // system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // converter tick every fourth clock, counted for length checks
   always @(posedge clk_sys_i) begin
      div <= div + 2'h1;
      adc_tick_i <= (div == 2'h3);
      if (adc_tick_i) tick_count <= tick_count + 1;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic wr_sel(input selection_t v);
      @(posedge clk_sys_i) begin
         sel_wr_i <= 1'b1;
         sel_wdata_i <= v;
      end
      @(posedge clk_sys_i) sel_wr_i <= 1'b0;
      #1;
   endtask : wr_sel

   task automatic pulse_start;
      @(posedge clk_sys_i) start_set_i <= 1'b1;
      @(posedge clk_sys_i) start_set_i <= 1'b0;
      #1;
   endtask : pulse_start

   task automatic pulse_clear;
      @(posedge clk_sys_i) done_clear_i <= 1'b1;
      @(posedge clk_sys_i) done_clear_i <= 1'b0;
      #1;
   endtask : pulse_clear

   // waits for the done flag, returns ticks since t0
   task automatic wait_done(input int t0, output int n);
      for (int i = 0; i < 400 && conversion_done_flag_o !== 1'b1; i++) begin
         @(posedge clk_sys_i);
         #1;
      end
      n = tick_count - t0;
      check(16'(conversion_done_flag_o), 16'h1, "conversion never completed");
   endtask : wait_done

   task automatic test_first_conv;
      int n;
      check(16'(sel_rdata_o), 16'h0, "buffered selection after reset");
      check(16'(applied_sel_o), 16'h0, "applied selection after reset");
      check(16'(busy_o), 16'h0, "busy after reset");
      wr_sel({REF_ANALOG_SUPPLY, 5'h03}); // single-ended, chosen before start
      repeat (3) @(posedge clk_sys_i);
      check(16'(applied_sel_o), 16'h23, "applied follows buffer when idle");
      pulse_start();
      wait_done(tick_count, n);
      // count includes the tick on which the conversion starts
      check(16'(n), 16'(FIRST_CYCLES + 1), "first conversion length");
      check(16'(result_o), 16'h155, "result at completion");
      check(16'(conversion_start_bit_o), 16'h0, "start bit kept in single mode");
      $display("test first conversion finished");
   endtask : test_first_conv

   task automatic test_lock;
      int n, t0;
      pulse_clear();
      pulse_start();
      t0 = tick_count;
      repeat (20) @(posedge clk_sys_i);
      wr_sel({REF_INTERNAL, 5'h05}); // written well after one converter cycle
      check(16'(sel_rdata_o), 16'h65, "buffer readable in conversion");
      check(16'(applied_sel_o), 16'h23, "applied changed mid conversion");
      check(16'(conversion_start_bit_o), 16'h1, "start bit during conversion");
      wait_done(t0, n);
      check(16'(n), 16'(NORMAL_CYCLES + 1), "normal conversion length");
      check(16'(applied_sel_o), 16'h65, "applied not resumed at end");
      $display("test selection lock finished");
   endtask : test_lock

   task automatic test_full_scale;
      int n;
      compare_over_ref_i <= 1'b1;
      pulse_clear();
      pulse_start();
      wait_done(tick_count, n);
      check(16'(result_o), 16'(FULL_SCALE), "over range result");
      compare_over_ref_i <= 1'b0;
      $display("test full scale finished");
   endtask : test_full_scale

   task automatic test_free_run;
      int n, t0;
      free_run_select_i <= 1'b1;
      wr_sel({REF_ANALOG_SUPPLY, 5'h02});
      pulse_clear();
      pulse_start();
      wait_done(tick_count, n);
      t0 = tick_count;
      wr_sel({REF_ANALOG_SUPPLY, 5'h07});
      pulse_clear();
      repeat (10) @(posedge clk_sys_i);
      check(16'(applied_sel_o), 16'h22, "auto conversion took new channel");
      check(16'(conversion_start_bit_o), 16'h1, "start bit dropped in free run");
      wait_done(t0, n);
      check(16'(n), 16'(NORMAL_CYCLES), "free run restart length");
      pulse_clear();
      repeat (10) @(posedge clk_sys_i);
      check(16'(applied_sel_o), 16'h27, "later conversion kept old channel");
      free_run_select_i <= 1'b0;
      wait_done(tick_count, n);
      pulse_clear();
      $display("test free running finished");
   endtask : test_free_run

   task automatic test_enable_refs_scan;
      int n;
      ref_switch_t exp [4];
      exp = '{3'b100, 3'b010, 3'b000, 3'b001};
      converter_enable_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      check(16'(analog_power_o), 16'h0, "power with converter off");
      pulse_start();
      repeat (12) @(posedge clk_sys_i);
      check(16'(busy_o), 16'h0, "start accepted while disabled");
      converter_enable_i <= 1'b1; // off and on forces an extended conversion
      repeat (2) @(posedge clk_sys_i);
      pulse_start();
      wait_done(tick_count, n);
      check(16'(n), 16'(FIRST_CYCLES + 1), "first conversion after enable");
      pulse_clear();
      for (int c = 0; c < 4; c++) begin
         wr_sel({2'(c), 5'h01}); // no conversion follows, no external drive
         repeat (3) @(posedge clk_sys_i);
         check(16'(ref_switch_o), 16'(exp[c]), "reference switch decode");
      end
      scan_enable_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      check(16'(upper_chan_avail_o), 16'h0, "upper pins kept with scan");
      scan_enable_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      check(16'(upper_chan_avail_o), 16'hf, "upper pins lost without scan");
      $display("test enable, references and scan finished");
   endtask : test_enable_refs_scan

   task automatic test_sleep;
      int n;
      int_enable_i <= 1'b1; // enabled, idle, single mode, request enabled
      sleep_canceler_mode_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      check(16'(irq_o), 16'h0, "request before sleep start");
      @(posedge clk_sys_i) cpu_halted_i <= 1'b1;
      @(posedge clk_sys_i);
      #1;
      wait_done(tick_count, n);
      check(16'(n), 16'(NORMAL_CYCLES + 1), "sleep started conversion");
      check(16'(irq_o), 16'h1, "completion request missing");
      check(16'(analog_power_o), 16'h1, "converter powered in sleep");
      cpu_halted_i <= 1'b0;
      sleep_canceler_mode_i <= 1'b0;
      pulse_clear();
      check(16'(irq_o), 16'h0, "request after clear");
      $display("test sleep start finished");
   endtask : test_sleep

   // watchdog against hangs
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      mismatches++;
      complete_run();
   end

   // main sequence
   initial begin
      {rst_n_i, adc_tick_i, sel_wr_i, start_set_i, done_clear_i, int_enable_i} = '0;
      {free_run_select_i, sleep_canceler_mode_i, cpu_halted_i, scan_enable_i} = '0;
      {compare_over_ref_i, div, tick_count, mismatches, check_count} = '0;
      ce_i = 1'b1;
      converter_enable_i = 1'b1;
      sel_wdata_i = '0;
      raw_result_i = 10'h155;
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      #1;
      test_first_conv();
      test_lock();
      test_full_scale();
      test_free_run();
      test_enable_refs_scan();
      test_sleep();
      complete_run();
   end
endmodule : test_adc_select_and_sleep_sequencer
`default_nettype wire
